// File: shared/dfcs_defines.svh
// constants for the data-flash command sequencer
// assumes a 32-bit axi4-lite register bus and a word-wide flash array port
`ifndef DFCS_DEFINES_SVH
`define DFCS_DEFINES_SVH

// ============================================================
// register byte offsets
`define DFCS_CONFIG_OFS 8'h00
`define DFCS_ERRCFG_OFS 8'h04
`define DFCS_STATUS_OFS 8'h08
`define DFCS_ERRSTAT_OFS 8'h0C
`define DFCS_INDEX_OFS 8'h10
`define DFCS_PARAM_OFS 8'h14
`define DFCS_PROT_OFS 8'h18
`define DFCS_MODE_OFS 8'h1C

// ============================================================
// field positions
`define DFCS_CMDIE_BIT 7
`define DFCS_DBL_BIT 1
`define DFCS_SGL_BIT 0
`define DFCS_CMPL_BIT 7
`define DFCS_AERR_BIT 5
`define DFCS_PVIOL_BIT 4
`define DFCS_MGANY_BIT 1
`define DFCS_MGUNC_BIT 0

// ============================================================
// command codes and indices
`define DFCS_CMD_EVSEC 8'h10
`define DFCS_CMD_PROG 8'h11
`define DFCS_CMD_ERSEC 8'h12
`define DFCS_IDX_EVSEC 3'h2
`define DFCS_IDX_PMIN 3'h2
`define DFCS_IDX_PMAX 3'h5
`define DFCS_IDX_ERSEC 3'h1

// ============================================================
// reset values and timing
`define DFCS_INIT_CYCLES 16'h0040
`define DFCS_ERASED_WORD 16'hFFFF
`define DFCS_RESP_OKAY 2'h0
`define DFCS_RESP_SLVERR 2'h2

`endif

// File: shared/dfcs_pkg.sv
// types shared by the data-flash command sequencer
// assumes dfcs_defines.svh carries the numbers
package dfcs_pkg;

  typedef enum logic [2:0] {
    DFCS_INIT,
    DFCS_IDLE,
    DFCS_CHECK,
    DFCS_ERASE,
    DFCS_WRITE,
    DFCS_VERIFY,
    DFCS_DONE
  } dfcs_state_e;

  typedef logic [15:0] dfcs_word_t;

endpackage : dfcs_pkg

// File: hdl/dfcs_axil_slave.sv
// axi4-lite register port of the sequencer
// assumes one aclk domain; one write and one read outstanding at most
`timescale 1ns/1ns
`default_nettype none
`include "dfcs_defines.svh"

module dfcs_axil_slave (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write channels
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read channels
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // register side
  output logic wr_stb,
  output logic [7:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  output logic [7:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_hit,
  input wire logic wr_hit
);

  logic aw_held;
  logic w_held;
  logic [7:0] aw_q;
  logic [31:0] w_q;
  logic [3:0] s_q;

  // ============================================================
  // write path: address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 32'h00000000;
      s_q <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_q <= wdata;
        s_q <= wstrb;
      end
      if (aw_held && w_held) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
    end
  end

  assign awready = !aw_held && !bvalid && aresetn;
  assign wready = !w_held && !bvalid && aresetn;
  assign wr_stb = aw_held && w_held;
  assign wr_addr = aw_q;
  assign wr_data = w_q;
  assign wr_strb = s_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= `DFCS_RESP_OKAY;
    end else if (wr_stb) begin
      bvalid <= 1'b1;
      bresp <= wr_hit ? `DFCS_RESP_OKAY : `DFCS_RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ============================================================
  // read path: one cycle from address to data
  assign arready = !rvalid && aresetn;
  assign rd_addr = araddr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `DFCS_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= rd_hit ? rd_data : 32'h00000000;
      rresp <= rd_hit ? `DFCS_RESP_OKAY : `DFCS_RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule : dfcs_axil_slave

`default_nettype wire

// File: hdl/dfcs_sequencer.sv
// data-flash command sequencer, top level
// assumes a word-wide flash array with one-cycle read, write and erase strobes
`timescale 1ns/1ns
`default_nettype none
`include "dfcs_defines.svh"

module dfcs_sequencer #(
  parameter int ADDR_W = 16,
  parameter logic [15:0] BLOCK_BASE = 16'h0000,
  parameter logic [15:0] BLOCK_WORDS = 16'h1000,
  parameter logic [15:0] SECTOR_WORDS = 16'h0080,
  parameter logic [6:0] BLOCK_SEL = 7'h10
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // flash array
  output logic [ADDR_W-1:0] array_addr,
  output logic array_rd,
  output logic array_wr,
  output logic array_erase,
  output logic [15:0] array_wdata,
  input wire logic [15:0] array_rdata,
  input wire logic array_ecc_single,
  input wire logic array_ecc_double,
  // power modes and interrupts
  input wire logic stop_req,
  output logic stop_ack,
  output logic cmd_irq,
  output logic err_irq
);
  import dfcs_pkg::*;

  dfcs_state_e state;
  logic wr_stb;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_hit;
  logic wr_hit;
  logic [2:0] param_index;
  dfcs_word_t command_param_word [0:5];
  logic command_complete_flag;
  logic command_complete_irq_enable;
  logic double_fault_irq_enable;
  logic single_fault_irq_enable;
  logic access_error_flag;
  logic protection_violation_flag;
  logic margin_status_any;
  logic margin_status_uncorrectable;
  logic double_fault_flag;
  logic single_fault_flag;
  logic [15:0] prot_lo;
  logic [15:0] prot_hi;
  logic cmd_allowed;
  logic [15:0] init_cnt;
  logic [15:0] cur;
  logic [15:0] last;
  logic [1:0] wsel;
  logic rd_pend;
  logic launch;
  logic fault_acc;
  logic fault_prot;
  logic [16:0] span_end;
  logic [16:0] next_span_end;
  logic [15:0] start;
  logic [15:0] sec_base;

  // ============================================================
  // bus slave
  dfcs_axil_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .wr_stb(wr_stb),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_hit(rd_hit),
    .wr_hit(wr_hit)
  );

  assign wr_hit = (wr_addr[1:0] == 2'h0) && (wr_addr <= `DFCS_MODE_OFS);

  // writing 1 to the complete bit launches, as if clearing the flag
  assign launch = wr_stb && wr_strb[0] && (wr_addr == `DFCS_STATUS_OFS) &&
                  wr_data[`DFCS_CMPL_BIT] && command_complete_flag &&
                  state == DFCS_IDLE;

  // ============================================================
  // read mux
  always_comb begin
    rd_hit = 1'b1;
    rd_data = 32'h00000000;
    case (rd_addr)
      `DFCS_CONFIG_OFS: rd_data[`DFCS_CMDIE_BIT] = command_complete_irq_enable;
      `DFCS_ERRCFG_OFS: begin
        rd_data[`DFCS_DBL_BIT] = double_fault_irq_enable;
        rd_data[`DFCS_SGL_BIT] = single_fault_irq_enable;
      end
      `DFCS_STATUS_OFS: begin
        rd_data[`DFCS_CMPL_BIT] = command_complete_flag;
        rd_data[`DFCS_AERR_BIT] = access_error_flag;
        rd_data[`DFCS_PVIOL_BIT] = protection_violation_flag;
        rd_data[`DFCS_MGANY_BIT] = margin_status_any;
        rd_data[`DFCS_MGUNC_BIT] = margin_status_uncorrectable;
      end
      `DFCS_ERRSTAT_OFS: begin
        rd_data[`DFCS_DBL_BIT] = double_fault_flag;
        rd_data[`DFCS_SGL_BIT] = single_fault_flag;
      end
      `DFCS_INDEX_OFS: rd_data[2:0] = param_index;
      `DFCS_PARAM_OFS: rd_data[15:0] = (param_index <= 3'h5) ?
                         command_param_word[param_index] : 16'h0000;
      `DFCS_PROT_OFS: rd_data = {prot_hi, prot_lo};
      `DFCS_MODE_OFS: rd_data[0] = cmd_allowed;
      default: rd_hit = 1'b0;
    endcase
  end

  // ============================================================
  // configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      command_complete_irq_enable <= 1'b0;
      double_fault_irq_enable <= 1'b0;
      single_fault_irq_enable <= 1'b0;
      prot_lo <= 16'hFFFF;
      prot_hi <= 16'hFFFF;
      cmd_allowed <= 1'b1;
    end else if (wr_stb && wr_strb[0]) begin
      case (wr_addr)
        `DFCS_CONFIG_OFS:
          command_complete_irq_enable <= wr_data[`DFCS_CMDIE_BIT];
        `DFCS_ERRCFG_OFS: begin
          double_fault_irq_enable <= wr_data[`DFCS_DBL_BIT];
          single_fault_irq_enable <= wr_data[`DFCS_SGL_BIT];
        end
        `DFCS_PROT_OFS: begin
          prot_lo <= wr_data[15:0];
          prot_hi <= wr_data[31:16];
        end
        `DFCS_MODE_OFS: cmd_allowed <= wr_data[0];
        default: ;
      endcase
    end
  end

  // ============================================================
  // index and parameter words, locked while a command or init runs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      param_index <= 3'h0;
      for (int i = 0; i < 6; i++) command_param_word[i] <= 16'h0000;
    end else if (wr_stb && command_complete_flag) begin
      if (wr_addr == `DFCS_INDEX_OFS && wr_strb[0])
        param_index <= wr_data[2:0];
      if (wr_addr == `DFCS_PARAM_OFS && param_index <= 3'h5) begin
        if (wr_strb[0]) command_param_word[param_index][7:0] <= wr_data[7:0];
        if (wr_strb[1])
          command_param_word[param_index][15:8] <= wr_data[15:8];
      end
    end
  end

  // ============================================================
  // launch checks
  assign start = command_param_word[1];
  assign sec_base = start & ~(SECTOR_WORDS - 16'h0001);

  always_comb begin
    fault_acc = 1'b0;
    fault_prot = 1'b0;
    next_span_end = {1'b0, start};
    case (command_param_word[0][15:8])
      `DFCS_CMD_EVSEC: begin
        fault_acc = param_index != `DFCS_IDX_EVSEC;
        // count is in words, addresses step by two
        next_span_end = {1'b0, start} + {command_param_word[2], 1'b0};
        fault_acc = fault_acc || command_param_word[2] == 16'h0000;
      end
      `DFCS_CMD_PROG: begin
        fault_acc = param_index < `DFCS_IDX_PMIN ||
                    param_index > `DFCS_IDX_PMAX;
        next_span_end = {1'b0, start} +
                        {13'h0000, param_index - 3'h1, 1'b0};
      end
      `DFCS_CMD_ERSEC: begin
        fault_acc = param_index != `DFCS_IDX_ERSEC;
        next_span_end = {1'b0, sec_base} + {SECTOR_WORDS, 1'b0};
      end
      default: fault_acc = 1'b1;
    endcase
    fault_acc = fault_acc || !cmd_allowed || start[0] ||
                command_param_word[0][6:0] != BLOCK_SEL ||
                start < BLOCK_BASE;
    // range
    if (next_span_end > {1'b0, BLOCK_BASE} + {BLOCK_WORDS, 1'b0})
      fault_acc = 1'b1;
    if (command_param_word[0][15:8] != `DFCS_CMD_EVSEC &&
        !(start < prot_lo || start > prot_hi))
      fault_prot = 1'b1;
  end

  // ============================================================
  // command engine; reset drops any command at once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= DFCS_INIT;
      init_cnt <= 16'h0000;
      command_complete_flag <= 1'b0;
      access_error_flag <= 1'b0;
      protection_violation_flag <= 1'b0;
      margin_status_any <= 1'b0;
      margin_status_uncorrectable <= 1'b0;
      cur <= 16'h0000;
      last <= 16'h0000;
      wsel <= 2'h0;
      rd_pend <= 1'b0;
      span_end <= 17'h00000;
      array_addr <= '0;
      array_rd <= 1'b0;
      array_wr <= 1'b0;
      array_erase <= 1'b0;
      array_wdata <= 16'h0000;
    end else begin
      array_rd <= 1'b0;
      array_wr <= 1'b0;
      array_erase <= 1'b0;
      case (state)
        DFCS_INIT: begin
          init_cnt <= init_cnt + 16'h0001;
          if (init_cnt == `DFCS_INIT_CYCLES) begin
            command_complete_flag <= 1'b1;
            state <= DFCS_IDLE;
          end
        end
        DFCS_IDLE: begin
          if (wr_stb && wr_addr == `DFCS_STATUS_OFS && wr_strb[0] &&
              command_complete_flag) begin
            // errors clear by writing one
            if (wr_data[`DFCS_AERR_BIT]) access_error_flag <= 1'b0;
            if (wr_data[`DFCS_PVIOL_BIT])
              protection_violation_flag <= 1'b0;
          end
          if (launch && !access_error_flag && !protection_violation_flag) begin
            command_complete_flag <= 1'b0;
            margin_status_any <= 1'b0;
            margin_status_uncorrectable <= 1'b0;
            state <= DFCS_CHECK;
          end
        end
        DFCS_CHECK: begin
          span_end <= next_span_end;
          wsel <= 2'h0;
          rd_pend <= 1'b0;
          if (fault_acc) begin
            access_error_flag <= 1'b1;
            state <= DFCS_DONE;
          end else if (fault_prot) begin
            protection_violation_flag <= 1'b1;
            state <= DFCS_DONE;
          end else if (command_param_word[0][15:8] == `DFCS_CMD_ERSEC) begin
            cur <= sec_base;
            last <= sec_base;
            state <= DFCS_ERASE;
          end else if (command_param_word[0][15:8] == `DFCS_CMD_PROG) begin
            cur <= start;
            last <= start;
            state <= DFCS_WRITE;
          end else begin
            cur <= start;
            last <= start;
            state <= DFCS_VERIFY;
          end
        end
        DFCS_ERASE: begin
          array_erase <= 1'b1;
          array_addr <= cur[ADDR_W-1:0];
          state <= DFCS_VERIFY;
        end
        DFCS_WRITE: begin
          array_wr <= 1'b1;
          array_addr <= cur[ADDR_W-1:0];
          array_wdata <= command_param_word[3'h2 + {1'b0, wsel}];
          cur <= cur + 16'h0002;
          wsel <= wsel + 2'h1;
          if ({1'b0, cur} + 17'h00002 >= span_end) begin
            cur <= last;
            wsel <= 2'h0;
            state <= DFCS_VERIFY;
          end
        end
        DFCS_VERIFY: begin
          // one read in flight; compare on the following cycle
          if (rd_pend) begin
            rd_pend <= 1'b0;
            if (array_ecc_single || array_ecc_double ||
                array_rdata != ((command_param_word[0][15:8] ==
                `DFCS_CMD_PROG) ? command_param_word[3'h2 + {1'b0, wsel}]
                : `DFCS_ERASED_WORD))
              margin_status_any <= 1'b1;
            if (array_ecc_double) margin_status_uncorrectable <= 1'b1;
            cur <= cur + 16'h0002;
            wsel <= wsel + 2'h1;
            if ({1'b0, cur} + 17'h00002 >= span_end) state <= DFCS_DONE;
          end else begin
            array_rd <= 1'b1;
            array_addr <= cur[ADDR_W-1:0];
            rd_pend <= 1'b1;
          end
        end
        DFCS_DONE: begin
          command_complete_flag <= 1'b1;
          state <= DFCS_IDLE;
        end
        default: state <= DFCS_IDLE;
      endcase
    end
  end

  // ============================================================
  // ecc fault flags; set beats a write-one clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      double_fault_flag <= 1'b0;
      single_fault_flag <= 1'b0;
    end else begin
      if (wr_stb && wr_strb[0] && wr_addr == `DFCS_ERRSTAT_OFS) begin
        if (wr_data[`DFCS_DBL_BIT]) double_fault_flag <= 1'b0;
        if (wr_data[`DFCS_SGL_BIT]) single_fault_flag <= 1'b0;
      end
      if (rd_pend && array_ecc_double) double_fault_flag <= 1'b1;
      if (rd_pend && array_ecc_single) single_fault_flag <= 1'b1;
    end
  end

  // ============================================================
  // interrupt levels and stop handshake; wait mode has no input here
  // since the engine never looks at it, which keeps commands running
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_irq <= 1'b0;
      err_irq <= 1'b0;
      stop_ack <= 1'b0;
    end else begin
      cmd_irq <= command_complete_flag &&
                 command_complete_irq_enable;
      err_irq <= (double_fault_flag && double_fault_irq_enable) ||
                 (single_fault_flag && single_fault_irq_enable);
      stop_ack <= stop_req && command_complete_flag &&
                  state == DFCS_IDLE && !launch;
    end
  end

endmodule : dfcs_sequencer

`default_nettype wire

// File: sim/dfcs_flash_model.sv
// flash array stand-in for the sequencer bench
// assumes one-cycle strobes; read data answered within the strobe cycle
`timescale 1ns/1ns
`default_nettype none

module dfcs_flash_model (
  // clock
  input wire logic aclk,
  // array port
  input wire logic [15:0] addr,
  input wire logic rd,
  input wire logic wr,
  input wire logic erase,
  input wire logic [15:0] wdata,
  input wire logic [1:0] inject,
  output logic [15:0] rdata,
  output logic ecc_single,
  output logic ecc_double
);
  // ==========
  // storage: 16 words, sectors of 8
  logic [15:0] mem [16];
  logic [15:0] idle_q;
  initial begin
    foreach (mem[i]) mem[i] = 16'hFFFF;
    idle_q = 16'h5A5A;
  end
  // programming only clears bits, so extra bits show up
  always @(posedge aclk) begin
    if (wr) mem[addr[4:1]] <= mem[addr[4:1]] & wdata;
    if (erase) for (int i = 0; i < 8; i++) mem[{addr[4], i[2:0]}] <= 16'hFFFF;
    // idle line toggles so a stale read is never taken for data
    idle_q <= ~idle_q;
  end
  // sequencer samples at the edge that ends its read strobe
  assign rdata = rd ? mem[addr[4:1]] : idle_q;
  assign ecc_double = rd & inject[1];
  assign ecc_single = rd & inject[0];
endmodule : dfcs_flash_model
`default_nettype wire

// File: sim/dfcs_properties.sv
// port assertions for the data-flash command sequencer
// assumes one aclk domain, synchronous active-low reset
`timescale 1ns/1ns
`default_nettype none

module dfcs_properties (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // flash array
  input wire logic array_rd,
  input wire logic array_wr,
  input wire logic array_erase,
  // power modes and interrupts
  input wire logic stop_req,
  input wire logic stop_ack,
  input wire logic cmd_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========
  // sequences
  sequence s_verify_soon;
    ##[1:40] array_rd;
  endsequence
  sequence s_quiet_start;
    !cmd_irq [*8];
  endsequence
  // ==========
  // properties
  a_erase_verifies: assert property (array_erase |-> s_verify_soon)
    else $error("erase not followed by verify reads");
  a_erase_one_pulse: assert property (array_erase |=> !array_erase)
    else $error("erase strobe repeated");
  a_prog_verifies: assert property (array_wr |-> ##[1:12] array_rd)
    else $error("program not followed by verify reads");
  a_busy_irq_low: assert property (array_erase |-> !cmd_irq)
    else $error("command interrupt while busy");
  a_stop_idle: assert property (stop_ack |-> !(array_rd || array_erase))
    else $error("stop granted during array work");
  a_stop_needs_req: assert property (!stop_req |=> !stop_ack)
    else $error("stop granted without request");
  a_init_quiet: assert property ($rose(aresetn) |-> s_quiet_start)
    else $error("complete interrupt during init");
  // reset itself is the cause here, so nothing disables it
  a_reset_abort: assert property (disable iff (1'b0)
    !aresetn |=> !array_wr && !array_erase && !cmd_irq)
    else $error("array strobe under reset");
endmodule : dfcs_properties

bind dfcs_sequencer dfcs_properties u_props (
  .aclk(aclk), .aresetn(aresetn), .array_rd(array_rd),
  .array_wr(array_wr), .array_erase(array_erase), .stop_req(stop_req),
  .stop_ack(stop_ack), .cmd_irq(cmd_irq));
`default_nettype wire

// File: sim/tb_top.sv
// self-checking bench for the data-flash command sequencer
// assumes dfcs_flash_model at the array port, 16-word block
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_errors++; \
  $display("BAD %0t %h %h", $time, a, b); end end

module tb_top;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, stop_req = 0, cie = 0;
  logic awready, wready, bvalid, arready, rvalid, rd, wr, er, es, ed;
  logic sack, cirq, eirq;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic [1:0] bresp, rresp, rsp, inj = 0;
  logic [15:0] aaddr, awd, ard;
  logic [98:0] bad [9] = '{{3'h1, 96'h2_0000_1010},
    {3'h3, 96'h2_0000_1010}, {3'h1, 96'h1234_0000_1110},
    {3'h6, 96'h1234_0000_1110}, {3'h2, 96'h0000_1210},
    {3'h2, 96'h1234_0001_1110}, {3'h2, 96'h2_0000_1011},
    {3'h2, 96'h4_001C_1010}, {3'h3, 96'h1234_1234_001E_1110}};
  int n_errors = 0, n_compared = 0;
  always #4 aclk = ~aclk;

  // ==========
  // design and array
  dfcs_sequencer #(.BLOCK_WORDS(16'h0010), .SECTOR_WORDS(16'h0008)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .array_addr(aaddr),
    .array_rd(rd), .array_wr(wr), .array_erase(er), .array_wdata(awd),
    .array_rdata(ard), .array_ecc_single(es), .array_ecc_double(ed),
    .stop_req(stop_req), .stop_ack(sack), .cmd_irq(cirq), .err_irq(eirq));
  dfcs_flash_model fm (.aclk(aclk), .addr(aaddr), .rd(rd), .wr(wr),
    .erase(er), .wdata(awd), .inject(inj), .rdata(ard), .ecc_single(es),
    .ecc_double(ed));

  // ==========
  // bus tasks; each ends off the edge so outputs have settled
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    while (!bvalid) @(posedge aclk);
    bready <= 0;
    rsp = bresp;
    @(negedge aclk);
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    do @(posedge aclk); while (!rvalid);
    rready <= 0;
    d = rdata;
    rsp = rresp;
    @(negedge aclk);
  endtask : rd_reg

  task automatic wait_done();
    do rd_reg(8'h08); while (d[7] !== 1'b1);
  endtask : wait_done

  task automatic reset_dut();
    @(posedge aclk);
    aresetn <= 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    wr_reg(8'h10, 32'h5);
    rd_reg(8'h08);
    `CHK(d[7], 1'b0)
    rd_reg(8'h10);
    `CHK(d[2:0], 3'h0)
    wait_done();
    cie = 0;
  endtask : reset_dut

  // params low word first: p0 code and block, p1 address, p2.. data
  task automatic launch(input logic [2:0] ix, input logic [95:0] p);
    for (int k = 0; k < 6; k++) begin
      wr_reg(8'h10, 32'(k));
      wr_reg(8'h14, {16'h0, p[16*k +: 16]});
    end
    wr_reg(8'h10, {29'h0, ix});
    wr_reg(8'h08, 32'h30);
    wr_reg(8'h08, 32'h80);
  endtask : launch

  task automatic cmd(input logic [2:0] ix, input logic [95:0] p,
    input logic [7:0] exp);
    launch(ix, p);
    if (exp[5:4] == 2'h0) `CHK({cirq, sack}, 2'h0)
    wait_done();
    `CHK(d[7:0], exp)
    `CHK({cirq, sack}, {cie, stop_req})
    $display("test %h done", p[15:0]);
  endtask : cmd

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  // ==========
  // tests
  initial begin
    reset_dut();
    // three programmed words from word 7
    cmd(3'h4, 96'h5A5A_ABCD_1234_000E_1110, 8'h80);
    `CHK({fm.mem[7], fm.mem[9], fm.mem[10]}, 48'h1234_5A5A_FFFF)
    wr_reg(8'h00, 32'h80);
    cie = 1;
    cmd(3'h2, 96'h1_000E_1010, 8'h82);
    cmd(3'h1, 96'h0004_1210, 8'h80);
    `CHK({fm.mem[7], fm.mem[8]}, 32'hFFFF_ABCD)
    cmd(3'h2, 96'h8_0000_1010, 8'h80);
    wr_reg(8'h18, 32'h001F_0000);
    cmd(3'h2, 96'h1234_0004_1110, 8'h90);
    cmd(3'h1, 96'h0012_1210, 8'h90);
    `CHK({fm.mem[2], fm.mem[8]}, 32'hFFFF_ABCD)
    wr_reg(8'h18, 32'hFFFF_FFFF);
    wr_reg(8'h04, 32'h3);
    for (int k = 1; k < 3; k++) begin
      @(posedge aclk);
      inj <= k[1:0];
      cmd(k[0] ? 3'h2 : 3'h1, k[0] ? 96'h2_0000_1010 : 96'h0000_1210,
        8'(8'h81 + k));
      rd_reg(8'h0C);
      `CHK({d[1:0], eirq}, {inj, 1'b1})
      wr_reg(8'h04, 32'h0);
      `CHK(eirq, 1'b0)
      wr_reg(8'h04, 32'h3);
      wr_reg(8'h0C, 32'h3);
      `CHK(eirq, 1'b0)
    end
    @(posedge aclk);
    inj <= 0;
    stop_req <= 1;
    cmd(3'h1, 96'h0010_1210, 8'h80);
    @(posedge aclk);
    stop_req <= 0;
    wr_reg(8'h00, 32'h0);
    cie = 0;
    for (int k = 0; k < 9; k++)
      cmd(bad[k][98:96], bad[k][95:0], 8'hA0);
    wr_reg(8'h1C, 32'h0);
    cmd(3'h2, 96'h1234_0000_1110, 8'hA0);
    wr_reg(8'h1C, 32'h1);
    rd_reg(8'h20);
    `CHK({rsp, d}, {2'h2, 32'h0})
    launch(3'h1, 96'h0010_1210);
    reset_dut();
    end_of_test();
  end

  initial begin
    repeat (30000) @(posedge aclk);
    n_errors++;
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
